// File: design/cmr_defs.svh
// register offsets, field positions and reset values of the buffer block
// ==========================================================================
`ifndef CMR_DEFS_SVH
`define CMR_DEFS_SVH

// ==========================================================================
// register byte offsets
`define CMR_OFF_MASK0   8'h00
`define CMR_OFF_MASK1   8'h04
`define CMR_OFF_MASK2   8'h08
`define CMR_OFF_FULL_LO 8'h0c
`define CMR_OFF_FULL_HI 8'h10
`define CMR_OFF_OVF_LO  8'h14
`define CMR_OFF_OVF_HI  8'h18
`define CMR_OFF_MSEL    8'h1c
`define CMR_OFF_CTL0    8'h20
`define CMR_OFF_CTL3    8'h2c
`define CMR_OFF_IRQ_ST  8'h30
`define CMR_OFF_IRQ_MSK 8'h34
`define CMR_OFF_TX_STAT 8'h38

// ==========================================================================
// buffer control byte fields
`define CMR_B_DIR  7
`define CMR_B_ABT  6
`define CMR_B_LARB 5
`define CMR_B_ERR  4
`define CMR_B_REQ  3
`define CMR_B_RTR  2
`define CMR_B_PRI  0

// ==========================================================================
// interrupt status bits, encodings and reset values
`define CMR_IRQ_RXFULL  0
`define CMR_IRQ_RX_BUFFER_OVERFLOW_FLAG   1
`define CMR_IRQ_TXOK    2
`define CMR_IRQ_TXFAULT 3
`define CMR_MSEL_NONE   2'h3
`define CMR_RESP_OK     2'h0
`define CMR_RESP_SLVERR 2'h2
`define CMR_RST16       16'h0000
`define CMR_RST8        8'h00
`define CMR_RST4        4'h0

`endif

// File: design/cmr_pkg.sv
// types shared by the buffer control block
package cmr_pkg;
	// transmit scheduler states, one-hot
	typedef enum logic [1:0] {
		CMR_IDLE = 2'b01,
		CMR_BUSY = 2'b10
	} cmr_state_t;
endpackage

// File: design/cmr_top.sv
// acceptance masks, receive flags and transmit buffer control of the CAN block
`timescale 1ns/1ns
`include "cmr_defs.svh"

module cmr_top (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        filt_req,
	input  wire logic [3:0]  filt_num,
	input  wire logic [15:0] filt_msg_id,
	input  wire logic [15:0] filt_code,
	output logic             filt_done,
	output logic             filt_hit,
	input  wire logic        rx_store_valid,
	input  wire logic [4:0]  rx_store_buf,
	input  wire logic        rtr_rx_valid,
	input  wire logic [2:0]  rtr_rx_buf,
	output logic             tx_start,
	output logic [2:0]       tx_buf,
	output logic             tx_abort,
	output logic [2:0]       tx_abort_buf,
	input  wire logic        tx_done_ok,
	input  wire logic        tx_lost_arb,
	input  wire logic        tx_bus_err,
	input  wire logic        tx_aborted,
	output logic             irq
);

	// ======================================================================
	// helpers
	// write-zero-to-clear on one 16-bit half, per byte lane
	function automatic logic [15:0] w0c(input logic [15:0] old,
		input logic hit, input logic [15:0] d, input logic [1:0] be);
		logic [15:0] keep;
		keep = {{8{~(hit & be[1])}}, {8{~(hit & be[0])}}} | d;
		return old & keep;
	endfunction

	// byte-enable merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] d, input logic [1:0] be);
		return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	// ======================================================================
	// state
	logic [15:0] mask_q [0:2];
	logic [31:0] msel_q;
	logic [31:0] full_q, ovf_q;
	logic [7:0]  dir_q, abt_q, larb_q, err_q, req_q, rtr_q;
	logic [1:0]  pri_q [0:7];
	logic [3:0]  irq_st_q, irq_msk_q;
	cmr_pkg::cmr_state_t st_q;
	logic [2:0]  cur_q;
	logic        aw_have_q, w_have_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;

	// ======================================================================
	// axi4-lite write side: address and data taken in either order
	wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
	wire wr_ok   = aw_addr_q[1:0] == 2'b00 &&
	               aw_addr_q <= `CMR_OFF_TX_STAT;
	wire wr_ctl  = wr_fire && wr_ok && aw_addr_q >= `CMR_OFF_CTL0 &&
	               aw_addr_q <= `CMR_OFF_CTL3;
	assign s_axi_awready = ~aw_have_q;
	assign s_axi_wready  = ~w_have_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			aw_addr_q    <= `CMR_RST8;
			w_data_q     <= {`CMR_RST16, `CMR_RST16};
			w_strb_q     <= `CMR_RST4;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CMR_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `CMR_RESP_OK : `CMR_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// named write strobes per register
	wire wr_hit_f = wr_fire & wr_ok;
	wire [15:0] wd = w_data_q[15:0];
	wire [1:0]  wb = w_strb_q[1:0];
	wire wr_full_lo = wr_hit_f && aw_addr_q == `CMR_OFF_FULL_LO;
	wire wr_full_hi = wr_hit_f && aw_addr_q == `CMR_OFF_FULL_HI;
	wire wr_ovf_lo  = wr_hit_f && aw_addr_q == `CMR_OFF_OVF_LO;
	wire wr_ovf_hi  = wr_hit_f && aw_addr_q == `CMR_OFF_OVF_HI;
	wire wr_msel    = wr_hit_f && aw_addr_q == `CMR_OFF_MSEL;
	wire wr_irq_st  = wr_hit_f && aw_addr_q == `CMR_OFF_IRQ_ST;
	wire wr_irq_msk = wr_hit_f && aw_addr_q == `CMR_OFF_IRQ_MSK;
	wire [1:0] ctl_pair = aw_addr_q[3:2];

	// per-buffer byte enables: even buffer low lane, odd high lane
	logic [7:0] bwe;
	logic [7:0] bdat [0:7];
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			bwe[i]  = wr_ctl && ctl_pair == 2'(i / 2) && w_strb_q[i % 2];
			bdat[i] = w_data_q[8 * (i % 2) +: 8];
		end
	end

	// ======================================================================
	// extended identifier masks and mask source selectors
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int m = 0; m < 3; m++) mask_q[m] <= `CMR_RST16;
			msel_q <= {`CMR_RST16, `CMR_RST16};
		end else begin
			for (int m = 0; m < 3; m++)
				if (wr_hit_f && aw_addr_q == `CMR_OFF_MASK0 + 8'(4 * m))
					mask_q[m] <= merge16(mask_q[m], wd, wb);
			if (wr_msel) begin
				msel_q[15:0]  <= merge16(msel_q[15:0], wd, wb);
				msel_q[31:16] <= merge16(msel_q[31:16],
				                         w_data_q[31:16], w_strb_q[3:2]);
			end
		end
	end

	// acceptance compare: a mask one bit takes part, a zero bit is ignored
	wire [1:0]  fsel   = msel_q[2 * filt_num +: 2];
	wire [15:0] fmask  = (fsel == `CMR_MSEL_NONE) ? 16'hffff :
	                     mask_q[fsel];
	wire        fmatch = ((filt_msg_id ^ filt_code) & fmask) == 16'h0000;

	// result registered so the data output comes from a flop
	always_ff @(posedge clk) begin
		if (rst) begin
			filt_done <= 1'b0;
			filt_hit  <= 1'b0;
		end else begin
			filt_done <= filt_req;
			if (filt_req) filt_hit <= fmatch;
		end
	end

	// ======================================================================
	// receive full and overflow flags; a set in the clear cycle wins
	wire [31:0] rx_set  = rx_store_valid ? (32'h1 << rx_store_buf) : 32'h0;
	wire [31:0] ovf_set = rx_set & full_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			full_q <= {`CMR_RST16, `CMR_RST16};
			ovf_q  <= {`CMR_RST16, `CMR_RST16};
		end else begin
			full_q <= {w0c(full_q[31:16], wr_full_hi, wd, wb),
			           w0c(full_q[15:0], wr_full_lo, wd, wb)} | rx_set;
			ovf_q  <= {w0c(ovf_q[31:16], wr_ovf_hi, wd, wb),
			           w0c(ovf_q[15:0], wr_ovf_lo, wd, wb)} | ovf_set;
		end
	end

	// ======================================================================
	// transmit selection: highest priority, lowest index on a tie
	wire [7:0] pend = dir_q & req_q;
	logic       pick_any;
	logic [2:0] pick_buf;
	always_comb begin
		pick_any = 1'b0;
		pick_buf = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (pend[i] && (!pick_any || pri_q[i] >= pri_q[pick_buf])) begin
				pick_any = 1'b1;
				pick_buf = 3'(i);
			end
	end

	wire busy     = st_q == cmr_pkg::CMR_BUSY;
	wire res_any  = busy & (tx_done_ok | tx_lost_arb | tx_bus_err | tx_aborted);

	// scheduler: one message on the bus at a time
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q     <= cmr_pkg::CMR_IDLE;
			cur_q    <= 3'h0;
			tx_start <= 1'b0;
			tx_buf   <= 3'h0;
		end else begin
			tx_start <= 1'b0;
			case (st_q)
				cmr_pkg::CMR_IDLE: begin
					if (pick_any) begin
						st_q     <= cmr_pkg::CMR_BUSY;
						cur_q    <= pick_buf;
						tx_buf   <= pick_buf;
						tx_start <= 1'b1;
					end
				end
				cmr_pkg::CMR_BUSY: begin
					if (res_any) st_q <= cmr_pkg::CMR_IDLE;
				end
				default: st_q <= cmr_pkg::CMR_IDLE;
			endcase
		end
	end

	// ======================================================================
	// buffer control fields; software abort of an idle buffer flags at once,
	// an in-flight one waits for the engine to confirm the abort
	logic [7:0] sw_set, sw_abort, hw_ok, rtr_set;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			hw_ok[i]    = busy && tx_done_ok && cur_q == 3'(i);
			sw_set[i]   = bwe[i] && bdat[i][`CMR_B_REQ] && !req_q[i];
			sw_abort[i] = bwe[i] && !bdat[i][`CMR_B_REQ] && req_q[i] &&
			              !hw_ok[i];
			rtr_set[i]  = rtr_rx_valid && rtr_rx_buf == 3'(i) &&
			              rtr_q[i] && dir_q[i];
		end
	end
	wire in_flight_abort = |(sw_abort & (busy ? (8'h1 << cur_q) : 8'h0));

	always_ff @(posedge clk) begin
		if (rst) begin
			dir_q  <= `CMR_RST8;
			abt_q  <= `CMR_RST8;
			larb_q <= `CMR_RST8;
			err_q  <= `CMR_RST8;
			req_q  <= `CMR_RST8;
			rtr_q  <= `CMR_RST8;
			for (int i = 0; i < 8; i++) pri_q[i] <= 2'h0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (busy && cur_q == 3'(i)) begin
					if (tx_done_ok) begin
						req_q[i] <= 1'b0;
						abt_q[i] <= 1'b0;
					end
					if (tx_aborted)  abt_q[i]  <= 1'b1;
					if (tx_lost_arb) larb_q[i] <= 1'b1;
					if (tx_bus_err)  err_q[i]  <= 1'b1;
				end
				if (bwe[i]) begin
					dir_q[i] <= bdat[i][`CMR_B_DIR];
					rtr_q[i] <= bdat[i][`CMR_B_RTR];
					pri_q[i] <= bdat[i][`CMR_B_PRI +: 2];
					req_q[i] <= bdat[i][`CMR_B_REQ];
				end
				if (sw_abort[i] && !(busy && cur_q == 3'(i)))
					abt_q[i] <= 1'b1;
				if (sw_set[i] || rtr_set[i]) begin
					req_q[i]  <= 1'b1;
					abt_q[i]  <= 1'b0;
					larb_q[i] <= 1'b0;
					err_q[i]  <= 1'b0;
				end
			end
		end
	end

	// abort request towards the protocol engine for the buffer on the bus
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_abort     <= 1'b0;
			tx_abort_buf <= 3'h0;
		end else begin
			tx_abort <= in_flight_abort;
			if (in_flight_abort) tx_abort_buf <= cur_q;
		end
	end

	// ======================================================================
	// interrupt: sticky events, write one to clear, set beats clear
	wire [3:0] irq_ev = {res_any & ~tx_done_ok, busy & tx_done_ok,
	                     |ovf_set, rx_store_valid};
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_st_q  <= `CMR_RST4;
			irq_msk_q <= `CMR_RST4;
		end else begin
			irq_st_q <= (irq_st_q & ~(wr_irq_st && wb[0] ? wd[3:0] : 4'h0))
			            | irq_ev;
			if (wr_irq_msk && wb[0]) irq_msk_q <= wd[3:0];
		end
	end
	assign irq = |(irq_st_q & irq_msk_q);

	// ======================================================================
	// read side: one read at a time, data registered
	logic [7:0] ctl_b [0:7];
	always_comb begin
		for (int i = 0; i < 8; i++)
			ctl_b[i] = {dir_q[i], abt_q[i], larb_q[i], err_q[i],
			            req_q[i], rtr_q[i], pri_q[i]};
	end

	wire [7:0] ra     = s_axi_araddr;
	wire [1:0] rpair  = ra[3:2];
	wire       rd_ok  = ra[1:0] == 2'b00 && ra <= `CMR_OFF_TX_STAT;
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0;
		if (rd_ok && ra >= `CMR_OFF_CTL0 && ra <= `CMR_OFF_CTL3)
			rd_val = {16'h0, ctl_b[{rpair, 1'b1}], ctl_b[{rpair, 1'b0}]};
		else
			case (ra)
				`CMR_OFF_MASK0:   rd_val = {16'h0, mask_q[0]};
				`CMR_OFF_MASK1:   rd_val = {16'h0, mask_q[1]};
				`CMR_OFF_MASK2:   rd_val = {16'h0, mask_q[2]};
				`CMR_OFF_FULL_LO: rd_val = {16'h0, full_q[15:0]};
				`CMR_OFF_FULL_HI: rd_val = {16'h0, full_q[31:16]};
				`CMR_OFF_OVF_LO:  rd_val = {16'h0, ovf_q[15:0]};
				`CMR_OFF_OVF_HI:  rd_val = {16'h0, ovf_q[31:16]};
				`CMR_OFF_MSEL:    rd_val = msel_q;
				`CMR_OFF_IRQ_ST:  rd_val = {28'h0, irq_st_q};
				`CMR_OFF_IRQ_MSK: rd_val = {28'h0, irq_msk_q};
				`CMR_OFF_TX_STAT: rd_val = {27'h0, cur_q, 1'b0, busy};
				default:          rd_val = 32'h0;
			endcase
	end

	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `CMR_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_ok ? `CMR_RESP_OK : `CMR_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ======================================================================
	// checks
	no_mask_a: assert property (@(posedge clk) disable iff (rst)
		filt_req && fsel == `CMR_MSEL_NONE && filt_msg_id != filt_code
		|=> filt_done && !filt_hit)
		else $error("no-mask filter matched a differing id");
	dont_care_a: assert property (@(posedge clk) disable iff (rst)
		filt_req && fsel != `CMR_MSEL_NONE && mask_q[fsel] == 16'h0
		|=> filt_hit)
		else $error("all-zero mask failed to accept");
	full_set_a: assert property (@(posedge clk) disable iff (rst)
		rx_store_valid |=> full_q[$past(rx_store_buf)])
		else $error("stored buffer not marked full");
	ovf_set_a: assert property (@(posedge clk) disable iff (rst)
		rx_store_valid && full_q[rx_store_buf]
		|=> ovf_q[$past(rx_store_buf)])
		else $error("store into full buffer missed overflow");
	full_keep_a: assert property (@(posedge clk) disable iff (rst)
		wr_full_lo && wd == 16'hffff
		|=> (($past(full_q[15:0]) & ~full_q[15:0]) == 16'h0))
		else $error("writing ones cleared a full flag");
	req_done_a: assert property (@(posedge clk) disable iff (rst)
		busy && tx_done_ok && !bwe[cur_q] && !rtr_set[cur_q]
		|=> !req_q[$past(cur_q)] && st_q == cmr_pkg::CMR_IDLE)
		else $error("send request not cleared after success");
	idle_abort_a: assert property (@(posedge clk) disable iff (rst)
		sw_abort[0] && !(busy && cur_q == 3'h0) |=> abt_q[0] && !req_q[0])
		else $error("software abort not flagged");
	remote_a: assert property (@(posedge clk) disable iff (rst)
		rtr_set[rtr_rx_buf] |=> req_q[$past(rtr_rx_buf)])
		else $error("remote frame did not queue reply");
	set_clr_a: assert property (@(posedge clk) disable iff (rst)
		sw_set[1] |=> req_q[1] && !abt_q[1] && !larb_q[1] && !err_q[1])
		else $error("request set left status flags");
	arb_lost_a: assert property (@(posedge clk) disable iff (rst)
		busy && tx_lost_arb |=> larb_q[$past(cur_q)] ##1 1'b1)
		else $error("arbitration loss not recorded");

endmodule // cmr_top

// File: verif/cmr_engine_model.sv
// behavioural model of the protocol engine beyond the block
`timescale 1ns/1ns

module cmr_engine_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       tx_start,
	input  wire logic       tx_abort,
	input  wire logic [1:0] fault,
	input  wire logic [3:0] lat,
	output logic            tx_done_ok,
	output logic            tx_lost_arb,
	output logic            tx_bus_err,
	output logic            tx_aborted
);
	logic       busy_q;
	logic       abt_q;
	logic [3:0] cnt_q;
	logic       gone;

	// an abort seen at any time in flight beats the bus outcome
	assign gone = abt_q | tx_abort;

	// ==========================================================
	// one result pulse per message (none for fault 3 unless aborted), lat+1 cycles after the start is taken in
	always_ff @(posedge clk) begin
		tx_done_ok  <= 1'b0;
		tx_lost_arb <= 1'b0;
		tx_bus_err  <= 1'b0;
		tx_aborted  <= 1'b0;
		if (rst) begin
			busy_q <= 1'b0;
			abt_q  <= 1'b0;
			cnt_q  <= 4'h0;
		end else if (!busy_q) begin
			busy_q <= tx_start;
			abt_q  <= 1'b0;
			cnt_q  <= lat;
		end else begin
			abt_q <= gone;
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h0) begin
				busy_q      <= 1'b0;
				tx_aborted  <= gone;
				tx_done_ok  <= !gone && fault == 2'h0;
				tx_lost_arb <= !gone && fault == 2'h1;
				tx_bus_err  <= !gone && fault == 2'h2;
			end
		end
	end
endmodule // cmr_engine_model

// File: verif/cmr_top_tb_top.sv
// self-checking bench for the mask, receive flag and buffer control block
`timescale 1ns/1ns
`include "cmr_defs.svh"

module cmr_top_tb_top;
	logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, filt_req;
	logic        filt_done, filt_hit, rx_store_valid, rtr_rx_valid;
	logic        tx_start, tx_abort, tx_done_ok, tx_lost_arb;
	logic        tx_bus_err, tx_aborted, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, filt_num, lat;
	logic [1:0]  s_axi_bresp, s_axi_rresp, fault;
	logic [15:0] filt_msg_id, filt_code, m, c, id;
	logic [4:0]  rx_store_buf;
	logic [2:0]  rtr_rx_buf, tx_buf, tx_abort_buf;
	logic [15:0] mk[3];
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	logic        hq[$];
	logic [2:0]  tq[$], aq[$];
	int          n_fail, tests_run;

	cmr_top          cmr_top_inst (.*);
	cmr_engine_model cmr_engine_model_inst (.*);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// checking and closing
	task automatic report_and_stop;
		$display("%0d checks, %0d wrong", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic tmo;
		n_fail++;
		$display("wrong value at %0t: wait timed out", $time);
		report_and_stop();
	endtask

	task automatic chk(input logic [33:0] e, input logic [33:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: want %h got %h", $time, e, g);
		end
	endtask

	// compare each answer with the oldest note as it appears
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready)
			chk(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			chk({32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
		if (filt_done)
			chk({33'h0, hq.pop_front()}, {33'h0, filt_hit});
		if (tx_start && tq.size() > 0)
			chk({31'h0, tq.pop_front()}, {31'h0, tx_buf});
		if (tx_abort)
			chk({31'h0, aq.pop_front()}, {31'h0, tx_abort_buf});
	end

	// ==========================================================
	// bus cycles; handshakes sampled at the falling edge, where the
	// levels equal those the next rising edge will see
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic aw_t, w_t, b_t;
		@(posedge clk);
		bq.push_back(r);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge clk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t  = s_axi_wvalid && s_axi_wready;
			b_t  = s_axi_bvalid;
			@(posedge clk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			if (b_t) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		tmo();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r);
		logic ar_t, r_t;
		@(posedge clk);
		rq.push_back({r, e});
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge clk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t  = s_axi_rvalid;
			@(posedge clk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			if (r_t) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		tmo();
	endtask

	// ==========================================================
	// side-band stimulus and bounded waits
	task automatic flt(input int k, input logic [15:0] i, input logic e);
		@(posedge clk);
		hq.push_back(e);
		filt_req    <= 1'b1;
		filt_num    <= 4'(k);
		filt_msg_id <= i;
		filt_code   <= c;
		@(posedge clk);
		filt_req <= 1'b0;
	endtask

	task automatic store(input logic [4:0] b);
		@(posedge clk);
		rx_store_valid <= 1'b1;
		rx_store_buf   <= b;
		@(posedge clk);
		rx_store_valid <= 1'b0;
	endtask

	task automatic rtr(input logic [2:0] b);
		@(posedge clk);
		rtr_rx_valid <= 1'b1;
		rtr_rx_buf   <= b;
		@(posedge clk);
		rtr_rx_valid <= 1'b0;
	endtask

	task automatic wt(input logic st);
		for (int n = 0; n < 60; n++) begin
			@(negedge clk);
			if (st ? tx_start : (tx_done_ok | tx_lost_arb | tx_bus_err |
				tx_aborted)) begin
				@(posedge clk);
				return;
			end
		end
		tmo();
	endtask

	task automatic chk_irq(input logic e);
		@(negedge clk);
		chk({33'h0, irq}, {33'h0, e});
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, filt_req, rx_store_valid, rtr_rx_valid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, filt_num} = '0;
		{filt_msg_id, filt_code, rx_store_buf, rtr_rx_buf, fault} = '0;
		{n_fail, tests_run, c} = '0;
		s_axi_wstrb = 4'hf;
		lat = 4'h0;
		rst = 1'b1;
		void'($urandom(32'h82752eae));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 15; a++) rd(8'(a * 4), 32'h0, `CMR_RESP_OK);
		rd(8'h3c, 32'h0, `CMR_RESP_SLVERR);
		wr(8'h3c, 32'h1, `CMR_RESP_SLVERR);
		// masks: one bit compares, zero ignores, per selector code
		foreach (mk[i]) begin
			mk[i] = 16'($urandom());
			wr(8'(i * 4), {16'h0, mk[i]}, `CMR_RESP_OK);
		end
		rd(`CMR_OFF_MASK1, {16'h0, mk[1]}, `CMR_RESP_OK);
		wr(`CMR_OFF_MSEL, 32'he4, `CMR_RESP_OK);
		for (int k = 0; k < 4; k++) begin
			m  = (k == 3) ? 16'hffff : mk[k];
			c  = 16'($urandom());
			id = c ^ (~m & 16'($urandom()));
			flt(k, id, 1'b1);
			id = 16'($urandom());
			flt(k, id, ((id ^ c) & m) == 16'h0);
		end
		// receive flags and the interrupt path
		store(5'd3);
		chk_irq(1'b0);
		wr(`CMR_OFF_IRQ_MSK, 32'h1, `CMR_RESP_OK);
		chk_irq(1'b1);
		store(5'd20);
		store(5'd3);
		rd(`CMR_OFF_FULL_LO, 32'h8, `CMR_RESP_OK);
		rd(`CMR_OFF_FULL_HI, 32'h10, `CMR_RESP_OK);
		rd(`CMR_OFF_OVF_LO, 32'h8, `CMR_RESP_OK);
		rd(`CMR_OFF_OVF_HI, 32'h0, `CMR_RESP_OK);
		wr(`CMR_OFF_FULL_LO, 32'hffff, `CMR_RESP_OK);
		rd(`CMR_OFF_FULL_LO, 32'h8, `CMR_RESP_OK);
		wr(`CMR_OFF_OVF_LO, 32'hfff7, `CMR_RESP_OK);
		rd(`CMR_OFF_OVF_LO, 32'h0, `CMR_RESP_OK);
		rd(`CMR_OFF_IRQ_ST, 32'h3, `CMR_RESP_OK);
		wr(`CMR_OFF_IRQ_ST, 32'h1, `CMR_RESP_OK);
		chk_irq(1'b0);
		rd(`CMR_OFF_IRQ_ST, 32'h2, `CMR_RESP_OK);
		// priority codes 0, 1 and 3, with a tie, on a slow engine
		lat <= 4'hf;
		tq = '{3'd2, 3'd3, 3'd1, 3'd0};
		wr(8'h24, 32'h8b8b, `CMR_RESP_OK);
		wr(`CMR_OFF_CTL0, 32'h8988, `CMR_RESP_OK);
		repeat (4) wt(1'b0);
		rd(`CMR_OFF_CTL0, 32'h8180, `CMR_RESP_OK);
		rd(8'h24, 32'h8383, `CMR_RESP_OK);
		// a receive buffer with a request never sends; clearing it aborts
		wr(`CMR_OFF_CTL0, 32'h0008, `CMR_RESP_OK);
		wr(`CMR_OFF_CTL0, 32'h0000, `CMR_RESP_OK);
		rd(`CMR_OFF_CTL0, 32'h0040, `CMR_RESP_OK);
		rd(`CMR_OFF_TX_STAT, 32'h0, `CMR_RESP_OK);
		// faults, then a software abort of the retry in flight
		for (int f = 1; f < 3; f++) begin
			fault <= 2'(f);
			tq.push_back(3'd6);
			wr(`CMR_OFF_CTL3, 32'h88, `CMR_RESP_OK);
			wt(1'b0);
			rd(`CMR_OFF_CTL3, 32'h88 | (32'h40 >> f), `CMR_RESP_OK);
			wt(1'b1);
			aq.push_back(3'd6);
			wr(`CMR_OFF_CTL3, 32'h80, `CMR_RESP_OK);
			wt(1'b0);
			rd(`CMR_OFF_CTL3, 32'hc0 | (32'h40 >> f), `CMR_RESP_OK);
		end
		fault <= 2'h0;
		tq.push_back(3'd6);
		wr(`CMR_OFF_CTL3, 32'h88, `CMR_RESP_OK);
		rd(`CMR_OFF_CTL3, 32'h88, `CMR_RESP_OK);
		wt(1'b0);
		rd(`CMR_OFF_CTL3, 32'h80, `CMR_RESP_OK);
		// remote frames on a prompt engine; a receive buffer never sends
		lat <= 4'h0;
		tq.push_back(3'd4);
		rtr(3'd6);
		wr(8'h28, 32'h0884, `CMR_RESP_OK);
		rtr(3'd4);
		wt(1'b0);
		rd(8'h28, 32'h0884, `CMR_RESP_OK);
		rd(`CMR_OFF_CTL3, 32'h80, `CMR_RESP_OK);
		// every expected start and abort must have been seen
		chk(34'h0, 34'(tq.size() + aq.size()));
		report_and_stop();
	end
endmodule // cmr_top_tb_top
